// ### src/poi_intensity_pwm.v
`timescale 1ns/1ps
`default_nettype none
`include "poi_consts.vh"

// Per-line intensity PWM: four code registers plus the master and line
// eight register, a step divider, a sixteen-phase counter and nine
// open-drain sink enables. Codes are double-buffered, so a write only
// reaches a line at a period boundary or while the oscillator is stopped.

module poi_intensity_pwm (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Register write port
    input  wire       regWrEn,
    input  wire [7:0] regWrAddr,
    input  wire [7:0] regWrData,
    // Register read port
    input  wire       regRdEn,
    input  wire [7:0] regRdAddr,
    output reg  [7:0] regRdData,
    output reg        regRdValid,
    // Open-drain drive lines, bit k is drive line k
    output reg  [8:0] driveOut,
    output reg  [8:0] driveEn,
    // Oscillator state
    output reg        oscRunning
);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Bit positions of the one-hot register select
    localparam SEL_MASTER = 0;
    localparam SEL_L10    = 1;
    localparam SEL_L32    = 2;
    localparam SEL_L54    = 3;
    localparam SEL_L76    = 4;

    reg [7:0] masterLineEight;
    reg [7:0] linesOneZero;
    reg [7:0] linesThreeTwo;
    reg [7:0] linesFiveFour;
    reg [7:0] linesSevenSix;

    // One-hot select of the mapped registers; shared by write and read
    function [4:0] regSel;
        input [7:0] addr;
        begin
            regSel = 5'h00;
            case (addr)
                `POI_ADDR_MASTER:    regSel[SEL_MASTER] = 1'b1;
                `POI_ADDR_LINES_1_0: regSel[SEL_L10]    = 1'b1;
                `POI_ADDR_LINES_3_2: regSel[SEL_L32]    = 1'b1;
                `POI_ADDR_LINES_5_4: regSel[SEL_L54]    = 1'b1;
                `POI_ADDR_LINES_7_6: regSel[SEL_L76]    = 1'b1;
                default: begin
                end
            endcase
        end
    endfunction

    // Decoded selects; an unmapped address selects nothing
    wire [4:0] wrSel = regWrEn ? regSel(regWrAddr) : 5'h00;
    wire [4:0] rdSel = regSel(regRdAddr);

    // Software writes; unmapped writes fall through untouched
    // Each register has its own select, so only one can load per write
    always @(posedge core_clk) begin
        if (rst) begin
            masterLineEight <= `POI_REG_RESET;
            linesOneZero    <= `POI_REG_RESET;
            linesThreeTwo   <= `POI_REG_RESET;
            linesFiveFour   <= `POI_REG_RESET;
            linesSevenSix   <= `POI_REG_RESET;
        end else begin
            if (wrSel[SEL_MASTER])
                masterLineEight <= regWrData;
            if (wrSel[SEL_L10])
                linesOneZero <= regWrData;
            if (wrSel[SEL_L32])
                linesThreeTwo <= regWrData;
            if (wrSel[SEL_L54])
                linesFiveFour <= regWrData;
            if (wrSel[SEL_L76])
                linesSevenSix <= regWrData;
        end
    end

    // Read mux; unmapped addresses return the idle value
    // A read and a write of one register in the same cycle
    // return the value held before that write
    wire [7:0] rdMux = (rdSel == 5'h00) ? `POI_RD_UNMAPPED :
                       (({8{rdSel[SEL_MASTER]}} & masterLineEight) |
                        ({8{rdSel[SEL_L10]}}    & linesOneZero)    |
                        ({8{rdSel[SEL_L32]}}    & linesThreeTwo)   |
                        ({8{rdSel[SEL_L54]}}    & linesFiveFour)   |
                        ({8{rdSel[SEL_L76]}}    & linesSevenSix));

    // Read-back one cycle after the request, same bit positions
    always @(posedge core_clk) begin
        if (rst) begin
            regRdData  <= `POI_RD_UNMAPPED;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn)
                regRdData <= rdMux;
        end
    end

    // ----------------------------------------
    // Oscillator and PWM phase
    // ----------------------------------------
    wire       masterOn = (masterLineEight[`POI_HI_NIB] != `POI_MASTER_OFF);
    reg  [7:0] stepCount;
    reg  [3:0] phase;
    wire       stepTick = masterOn && (stepCount == `POI_STEP_LAST);
    wire       periodEnd = stepTick && (phase == `POI_PHASE_LAST);

    // One PWM period is sixteen steps of the divider. Line k sinks for
    // phases 0 to its code, so code n gives n+1 steps of sixteen.
    // The drive flops trail the phase by one clock; the lag is the same
    // for every line, so duty and alignment are unaffected.
    // Stopping the master resets divider and phase, so the next start
    // always begins with a full first step.

    // Divider and 16-step phase counter; both halt when master is zero
    // Holding them in reset avoids a short first step after a restart
    always @(posedge core_clk) begin
        if (rst) begin
            stepCount  <= 8'h00;
            phase      <= `POI_PHASE_FIRST;
        end else begin
            if (!masterOn) begin
                stepCount <= 8'h00;
                phase     <= `POI_PHASE_FIRST;
            end else if (stepTick) begin
                stepCount <= 8'h00;
                phase     <= phase + 4'h1;
            end else begin
                stepCount <= stepCount + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Oscillator state flag
    // ----------------------------------------
    // Mirrors the master gate one clock late, as a registered output
    always @(posedge core_clk) begin
        if (rst) begin
            oscRunning <= 1'b0;
        end else begin
            oscRunning <= masterOn;
        end
    end

    // ----------------------------------------
    // Per-line codes and drive
    // ----------------------------------------
    // Written codes in line order, line eight on top
    wire [35:0] regCodes = {masterLineEight[`POI_LO_NIB], linesSevenSix, linesFiveFour,
                            linesThreeTwo, linesOneZero};
    // Live copies of the codes, one nibble per line
    reg  [35:0] liveCodes;

    // New codes are taken only where no pulse is in flight: at the last
    // tick of a period, or while the oscillator is stopped. A write in
    // mid-period therefore cannot cut or stretch the running pulse.
    wire        codeLoad = periodEnd || !masterOn;

    // Open-drain pins never drive a high level; the level stays low
    always @(posedge core_clk) begin
        if (rst) begin
            driveOut <= 9'h000;
        end else begin
            driveOut <= 9'h000;
        end
    end

    // Sink enable for a code at the given phase. Phase runs 0 to 15, so
    // code n sinks for n+1 phases; the all-ones code bypasses the compare
    // because its static level must not depend on the phase at all.
    function sinkAt;
        input [3:0] code;
        input [3:0] ph;
        begin
            if (code == `POI_CODE_STATIC)
                sinkAt = 1'b1;
            else
                sinkAt = (ph <= code);
        end
    endfunction

    genvar k;
    generate
        for (k = 0; k < `POI_NUM_LINES; k = k + 1) begin : gLine
            // Code latched only at the period boundary or while stopped
            always @(posedge core_clk) begin
                if (rst) begin
                    liveCodes[4*k+3:4*k] <= 4'h0;
                end else if (codeLoad) begin
                    liveCodes[4*k+3:4*k] <= regCodes[4*k+3:4*k];
                end
            end

            // Open-drain drive: level is low, enable sinks current
            always @(posedge core_clk) begin
                if (rst) begin
                    driveEn[k]  <= 1'b0;
                end else begin
                    if (!masterOn)
                        driveEn[k] <= 1'b0;
                    else
                        driveEn[k] <= sinkAt(liveCodes[4*k+3:4*k], phase);
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ### src/poi_consts.vh
// Behaviour
// - Register 0x10 holds line one code in bits 7:4, line zero in 3:0.
// - Code n from 0 to 14 gives PWM duty of (n+1)/16.
// - Code all ones gives full duty: static level, no PWM switching.
// - Register 0x11 holds line three code upper nibble, line two lower.
// - Register 0x12 holds line five code upper nibble, line four lower.
// - Register 0x13 holds line seven code upper nibble, line six lower.
// - Intensity registers are writable and read back in the same bit positions.
// - Line eight code sits in the lower nibble of register 0x0E.
// - Master field zero stops the oscillator; all lines static, no PWM.
`ifndef POI_CONSTS_VH
`define POI_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define POI_ADDR_MASTER     8'h0e
`define POI_ADDR_LINES_1_0  8'h10
`define POI_ADDR_LINES_3_2  8'h11
`define POI_ADDR_LINES_5_4  8'h12
`define POI_ADDR_LINES_7_6  8'h13

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define POI_LO_NIB          3:0
`define POI_HI_NIB          7:4
`define POI_REG_RESET       8'h00
`define POI_CODE_STATIC     4'hf
`define POI_MASTER_OFF      4'h0
`define POI_RD_UNMAPPED     8'h00

// ----------------------------------------
// Timing: oscillator step of the PWM
// ----------------------------------------
`define POI_CLK_NS          100
`define POI_STEP_NS         1000
`define POI_STEP_CYCLES     ((`POI_STEP_NS) / (`POI_CLK_NS))
`define POI_STEP_LAST       8'd9
`define POI_PHASE_LAST      4'hf
`define POI_PHASE_FIRST     4'h0
`define POI_NUM_LINES       9

`endif

// ### verification/poi_pwm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module poi_pwm_checker (
    // Ports of the pwm block
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdAddr,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic [8:0] driveOut,
    input wire logic [8:0] driveEn,
    input wire logic       oscRunning
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    rd_valid_a: assert property (regRdEn |=> regRdValid) else $error("no valid");
    rd_pulse_a: assert property (!regRdEn |=> !regRdValid) else $error("extra valid");
    rd_hold_a: assert property (!regRdEn |=> $stable(regRdData)) else $error("moved");
    rd_unmapped_a: assert property (regRdEn && regRdAddr > 8'h13 |=> regRdData == 8'h00)
        else $error("unmapped data");
    osc_follow_a: assert property (regWrEn && regWrAddr == 8'h0e |-> ##2
        oscRunning == ($past(regWrData, 2) > 8'h0f)) else $error("osc state");
    stop_static_a: assert property (!oscRunning [*2] |-> driveEn == 9'h000)
        else $error("pwm while stopped");
    sink_only_a: assert property (driveOut == 9'h000) else $error("pin driven");
    min_pulse_a: assert property ($fell(driveEn[0]) && oscRunning |-> $past(driveEn[0], 10))
        else $error("short pulse");
    cover property (regRdValid && regRdData != 8'h00);
    cover property ($fell(oscRunning));
    cover property ($rose(driveEn[8]));
endmodule
bind poi_intensity_pwm poi_pwm_checker chk_u (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdEn(regRdEn), .regRdAddr(regRdAddr),
    .regRdData(regRdData), .regRdValid(regRdValid), .driveOut(driveOut), .driveEn(driveEn),
    .oscRunning(oscRunning));
`default_nettype wire

// ### verification/poi_led_load.sv
`timescale 1ns/1ps
`default_nettype none
module poi_led_load (
    // Open-drain pins and the level the load sees
    input  wire logic [8:0] driveOut,
    input  wire logic [8:0] driveEn,
    output wire logic [8:0] lineLevel
);
    // Pull-up wins wherever a pin is released
    assign lineLevel = (driveEn & driveOut) | ~driveEn;
endmodule
`default_nettype wire

// ### verification/poi_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----
    // Stimulus and checks
    // ----
    logic       core_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, regRdValid, oscRunning;
    logic [7:0] regWrAddr = 8'h00, regWrData = 8'h00, regRdAddr = 8'h00, regRdData;
    logic [8:0] driveOut, driveEn, lineLevel;
    int         n_mismatch = 0, check_count = 0, cyc = 0;
    // Address in upper byte, written and read-back data in lower byte
    logic [15:0] rows [5] = '{16'h10f3, 16'h110e, 16'h1270, 16'h13a5, 16'h0e5a};
    poi_intensity_pwm dut_u (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn),
        .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdEn(regRdEn), .regRdAddr(regRdAddr),
        .regRdData(regRdData), .regRdValid(regRdValid), .driveOut(driveOut),
        .driveEn(driveEn), .oscRunning(oscRunning));
    poi_led_load load_u (.driveOut(driveOut), .driveEn(driveEn), .lineLevel(lineLevel));
    always #50 core_clk = ~core_clk;
    // Cycle ceiling against hangs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task chk(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        regWrEn <= 1'b1;
        regWrAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        regRdEn <= 1'b1;
        regRdAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(posedge core_clk);
        d = regRdData;
        chk({8'h00, regRdValid}, 9'h001);
    endtask
    task tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] d;
        logic [3:0] c;
        int         lowCnt [9];
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i][15:8], rows[i][7:0]);
            rd(rows[i][15:8], d);
            chk({1'b0, d}, {1'b0, rows[i][7:0]});
        end
        // One full period on every line
        repeat (200) @(posedge core_clk);
        lowCnt = '{default: 0};
        repeat (160) begin
            @(posedge core_clk);
            foreach (lowCnt[k]) lowCnt[k] += !lineLevel[k];
        end
        for (int k = 0; k < 9; k++) begin
            c = (k == 8) ? rows[4][3:0] : rows[k >> 1][4 * (k & 1) +: 4];
            chk(9'(lowCnt[k]), 9'(c == 4'hf ? 160 : 10 * c + 10));
        end
        wr(8'h0e, 8'h0a);
        repeat (3) @(posedge core_clk);
        chk(driveEn, 9'h000);
        chk({8'h00, oscRunning}, 9'h000);
        wr(8'h14, 8'h55);
        rd(8'h14, d);
        chk({1'b0, d}, 9'h000);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h13, d);
        chk({1'b0, d}, 9'h000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
